// File: core/fpec_flash_ctrl.v
`timescale 1ns/10ps
`include "fpec_map.vh"

// Overview of operation
// - Overlay only in user or user-program mode
// - Overlay source fixed at 1-kbyte RAM window
// - Overlay replaces one selected 1-kbyte small block
// - Select field decodes upper two bits only
// - Flash and RAM addresses hit same bytes
// - Emulation select blocks program and erase
// - Clearing emulation select removes overlay
// - Erase never touches overlay RAM
// - Control 1 picks program, verify, erase modes
// - Latch 128 bytes from 00 or 80 start
// - Program pulse lasts while write strobe set
// - Erase lasts while clear strobe set
// - FF dummy write then longword verify reads
// - Mask all interrupts during program, erase, boot
// - Reset or standby aborts and clears registers; standby keeps RAM emulation
// - Without unlock, write and clear strobes enter no mode; verify bits still do
// - Erase block registers enable erasure per block
// - Flash read, exception or sleep during program or erase sets fault
// - Fault keeps registers, blocks program and erase
// - Only power-on reset clears fault
module fpec_flash_ctrl #(
  parameter LATCH_BYTES = 128
) (
  input wire clock,
  input wire reset_n,
  input wire powerOnReset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire standby,
  input wire userMode,
  input wire bootRunning,
  input wire cpuValid,
  input wire cpuWrite,
  input wire cpuFetch,
  input wire [23:0] cpuAddr,
  input wire [7:0] cpuWdata,
  input wire exceptionTaken,
  input wire sleepExec,
  output reg overlayHit,
  output reg [23:0] physAddr,
  output reg irqMask,
  output reg writePulse,
  output reg clrPulse,
  output reg [7:0] eraseBlocks,
  output reg writeCheck,
  output reg clrCheck,
  output reg latchFull,
  output reg [23:0] latchBase,
  output reg verifyArmed,
  output reg [23:0] verifyAddr
);

  // ----------------------------------------
  // Operating states
  // ----------------------------------------
  localparam ST_IDLE = 4'b0001;
  localparam ST_PROG = 4'b0010;
  localparam ST_ERASE = 4'b0100;
  localparam ST_VERIFY = 4'b1000;

  reg [7:0] ctrl1_q;
  reg [7:0] ebs1_q;
  reg [7:0] ebs2_q;
  reg [7:0] ramEmu_q;
  reg fault_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [7:0] latchCnt_q;
  reg [7:0] latchMem_q [0:LATCH_BYTES-1];
  reg [23:0] latchBase_q;
  reg verifyArmed_q;
  reg [23:0] verifyAddr_q;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function [23:0] blockBase;
    input [1:0] sel;
    begin
      blockBase = {12'h000, sel, 10'h000};
    end
  endfunction

  function inFlash;
    input [23:0] a;
    begin
      inFlash = (a <= `FPEC_FLASH_TOP);
    end
  endfunction

  // ----------------------------------------
  // Overlay decode
  // ----------------------------------------
  function overlaySel;
    input [23:0] a;
    input [1:0] blk;
    begin
      overlaySel = ((a & 24'hFFFC00) == blockBase(blk));
    end
  endfunction

  function [23:0] ramAlias;
    input [23:0] a;
    begin
      ramAlias = `FPEC_EMU_RAM_BASE | {14'h0000, a[9:0]};
    end
  endfunction

  // ----------------------------------------
  // Mode request decode
  // ----------------------------------------
  function [3:0] pickMode;
    input wrReq;
    input clrReq;
    input chkReq;
    begin
      if (wrReq) begin
        pickMode = ST_PROG;
      end else if (clrReq) begin
        pickMode = ST_ERASE;
      end else if (chkReq) begin
        pickMode = ST_VERIFY;
      end else begin
        pickMode = ST_IDLE;
      end
    end
  endfunction

  // ----------------------------------------
  // Register read decode
  // ----------------------------------------
  function [31:0] readWord;
    input [11:0] a;
    begin
      case (a)
        `FPEC_OFS_CTRL1: readWord = {24'h000000, ctrl1_q};
        `FPEC_OFS_CTRL2: readWord = {24'h000000, fault_q, 7'h00};
        `FPEC_OFS_EBS1: readWord = {24'h000000, ebs1_q};
        `FPEC_OFS_EBS2: readWord = {24'h000000, ebs2_q};
        `FPEC_OFS_RAMEMU: readWord = {24'h000000, ramEmu_q};
        `FPEC_OFS_STAT: readWord = {20'h00000, state_q, latchCnt_q};
        default: readWord = 32'h00000000;
      endcase
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      case (a)
        `FPEC_OFS_CTRL1, `FPEC_OFS_CTRL2, `FPEC_OFS_EBS1,
        `FPEC_OFS_EBS2, `FPEC_OFS_RAMEMU, `FPEC_OFS_STAT: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  wire hwProtect = standby;
  wire emuOn = ramEmu_q[`FPEC_RE_SEL] & userMode;
  wire [1:0] emuBlk = ramEmu_q[`FPEC_RE_BLKHI:`FPEC_RE_BLKLO];
  wire unlocked = ctrl1_q[`FPEC_C1_UNLOCK];
  wire strobeOk = unlocked & ~ramEmu_q[`FPEC_RE_SEL] & ~fault_q
                  & ~hwProtect;
  wire anyBlock = (ebs1_q != 8'h00) | (ebs2_q != 8'h00);
  wire active = (state_q == ST_PROG) | (state_q == ST_ERASE);
  wire flashRead = cpuValid & ~cpuWrite & inFlash(cpuAddr);
  wire fetchFlash = cpuFetch & inFlash(cpuAddr);
  wire faultCause = flashRead | fetchFlash | exceptionTaken | sleepExec;
  wire faultEvt = active & faultCause;
  wire overlayAddr = emuOn & overlaySel(cpuAddr, emuBlk);
  wire progReq = strobeOk & ctrl1_q[`FPEC_C1_WRITE];
  wire eraseReq = strobeOk & ctrl1_q[`FPEC_C1_CLR] & anyBlock;
  wire checkReq = ctrl1_q[`FPEC_C1_WCHK] | ctrl1_q[`FPEC_C1_CCHK];
  wire apbWr = psel & penable & pwrite;

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  always @* begin
    state_d = ST_IDLE;
    case (state_q)
      ST_IDLE: begin
        state_d = pickMode(progReq, eraseReq, checkReq);
      end
      ST_PROG: begin
        // Fault abort drops to idle
        if (faultEvt) begin
          state_d = ST_IDLE;
        end else begin
          state_d = pickMode(progReq, eraseReq, checkReq);
        end
      end
      ST_ERASE: begin
        if (faultEvt) begin
          state_d = ST_IDLE;
        end else begin
          state_d = pickMode(progReq, eraseReq, checkReq);
        end
      end
      ST_VERIFY: begin
        state_d = pickMode(progReq, eraseReq, checkReq);
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers and fault
  // ----------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl1_q <= 8'h00;
      ebs1_q <= 8'h00;
      ebs2_q <= 8'h00;
      ramEmu_q <= 8'h00;
      state_q <= ST_IDLE;
    end else if (hwProtect) begin
      ctrl1_q <= 8'h00;
      ebs1_q <= 8'h00;
      ebs2_q <= 8'h00;
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
      if (apbWr) begin
        case (paddr)
          `FPEC_OFS_CTRL1: ctrl1_q <= pwdata[7:0];
          `FPEC_OFS_EBS1: ebs1_q <= pwdata[7:0];
          `FPEC_OFS_EBS2: ebs2_q <= pwdata[7:0];
          `FPEC_OFS_RAMEMU: ramEmu_q <= pwdata[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  always @(posedge clock or negedge powerOnReset_n) begin
    if (!powerOnReset_n) begin
      fault_q <= 1'b0;
    end else if (faultEvt) begin
      fault_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Program latch and verify address
  // ----------------------------------------
  integer i;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      latchCnt_q <= 8'h00;
      latchBase_q <= 24'h000000;
      verifyArmed_q <= 1'b0;
      verifyAddr_q <= 24'h000000;
      for (i = 0; i < LATCH_BYTES; i = i + 1) begin
        latchMem_q[i] <= 8'h00;
      end
    end else begin
      if (cpuValid & cpuWrite & inFlash(cpuAddr) & ~overlayAddr &
          ~active) begin
        if (cpuWdata == `FPEC_ERASED_BYTE && cpuAddr[1:0] == 2'b00 &&
            (ctrl1_q[`FPEC_C1_WCHK] | ctrl1_q[`FPEC_C1_CCHK])) begin
          verifyArmed_q <= 1'b1;
          verifyAddr_q <= cpuAddr;
        end else if (unlocked) begin
          if (latchCnt_q == 8'h00 || latchCnt_q == `FPEC_LATCH_BYTES) begin
            if (cpuAddr[6:0] == 7'h00) begin
              latchBase_q <= cpuAddr;
              latchMem_q[0] <= cpuWdata;
              latchCnt_q <= 8'h01;
            end
          end else begin
            latchMem_q[latchCnt_q[6:0]] <= cpuWdata;
            latchCnt_q <= latchCnt_q + 8'h01;
          end
        end
      end
      if (state_q == ST_PROG && state_d != ST_PROG) begin
        latchCnt_q <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      overlayHit <= 1'b0;
      physAddr <= 24'h000000;
      irqMask <= 1'b0;
      writePulse <= 1'b0;
      clrPulse <= 1'b0;
      eraseBlocks <= 8'h00;
      writeCheck <= 1'b0;
      clrCheck <= 1'b0;
      latchFull <= 1'b0;
      latchBase <= 24'h000000;
      verifyArmed <= 1'b0;
      verifyAddr <= 24'h000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        prdata <= readWord(paddr);
        pslverr <= ~mapped(paddr);
      end
      overlayHit <= overlayAddr;
      physAddr <= overlayAddr ? ramAlias(cpuAddr) : cpuAddr;
      irqMask <= active | (state_d == ST_PROG) | (state_d == ST_ERASE) |
                 bootRunning;
      writePulse <= (state_d == ST_PROG);
      clrPulse <= (state_d == ST_ERASE);
      eraseBlocks <= ebs1_q | ebs2_q;
      writeCheck <= (state_d == ST_VERIFY) & ctrl1_q[`FPEC_C1_WCHK];
      clrCheck <= (state_d == ST_VERIFY) & ctrl1_q[`FPEC_C1_CCHK];
      latchFull <= (latchCnt_q == `FPEC_LATCH_BYTES);
      latchBase <= latchBase_q;
      verifyArmed <= verifyArmed_q;
      verifyAddr <= verifyAddr_q;
    end
  end

endmodule

// File: core/fpec_map.vh
`ifndef FPEC_MAP_VH
`define FPEC_MAP_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FPEC_OFS_CTRL1 12'h000
`define FPEC_OFS_CTRL2 12'h004
`define FPEC_OFS_EBS1 12'h008
`define FPEC_OFS_EBS2 12'h00C
`define FPEC_OFS_RAMEMU 12'h010
`define FPEC_OFS_STAT 12'h014
// ----------------------------------------
// Control 1 fields
// ----------------------------------------
`define FPEC_C1_WRITE 0
`define FPEC_C1_CLR 1
`define FPEC_C1_WCHK 2
`define FPEC_C1_CCHK 3
`define FPEC_C1_UNLOCK 6
// ----------------------------------------
// Control 2 and emulation fields
// ----------------------------------------
`define FPEC_C2_FAULT 7
`define FPEC_RE_SEL 3
`define FPEC_RE_BLKHI 2
`define FPEC_RE_BLKLO 1
// ----------------------------------------
// Address windows
// ----------------------------------------
`define FPEC_EMU_RAM_BASE 24'hFFE000
`define FPEC_EMU_RAM_TOP 24'hFFE3FF
`define FPEC_FLASH_TOP 24'h00FFFF
`define FPEC_LATCH_BYTES 8'h80
`define FPEC_ERASED_BYTE 8'hFF
`endif

// File: verif/fpec_cpu_model.sv
`timescale 1ns/10ps
module fpec_cpu_model (
  input wire clock,
  output reg cpuValid,
  output reg cpuWrite,
  output reg [23:0] cpuAddr,
  output reg [7:0] cpuWdata,
  output reg exceptionTaken
);
  initial begin
    {cpuValid, cpuWrite, exceptionTaken} = 3'h0;
    cpuAddr = 24'h000000;
    cpuWdata = 8'h00;
  end
  // ----------------------------------------
  // Byte access; released lines show inverse
  // ----------------------------------------
  task acc(input w, input [23:0] a, input [7:0] d);
    begin
      @(posedge clock);
      {cpuValid, cpuWrite, cpuAddr, cpuWdata} <= {1'b1, w, a, d};
      @(posedge clock);
      {cpuValid, cpuAddr, cpuWdata} <= {1'b0, ~a, ~d};
    end
  endtask
  task exc;
    begin
      @(posedge clock);
      exceptionTaken <= 1'b1;
      @(posedge clock);
      exceptionTaken <= 1'b0;
    end
  endtask
endmodule

// File: verif/fpec_flash_ctrl_tb.sv
`timescale 1ns/10ps
`include "fpec_map.vh"
module fpec_flash_ctrl_tb;
  reg clock = 1'b0, reset_n = 1'b0, powerOnReset_n = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  reg standby = 1'b0, userMode = 1'b0, bootRunning = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  wire pready, pslverr, overlayHit, irqMask, writePulse, clrPulse, clrCheck;
  wire writeCheck;
  wire latchFull, verifyArmed, cpuValid, cpuWrite, exceptionTaken;
  wire [31:0] prdata;
  wire [23:0] physAddr, latchBase, verifyAddr, cpuAddr;
  wire [7:0] eraseBlocks, cpuWdata;
  integer error_cnt = 0, num_checks = 0, cyc = 0, i;
  always #10 clock = ~clock;
  fpec_cpu_model cpu (.clock, .cpuValid, .cpuWrite, .cpuAddr, .cpuWdata,
    .exceptionTaken);
  fpec_flash_ctrl dut (.clock, .reset_n, .powerOnReset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .standby,
    .userMode, .bootRunning, .cpuValid, .cpuWrite, .cpuFetch(1'b0),
    .cpuAddr, .cpuWdata, .exceptionTaken, .sleepExec(1'b0), .overlayHit,
    .physAddr, .irqMask, .writePulse, .clrPulse, .eraseBlocks,
    .writeCheck, .clrCheck, .latchFull, .latchBase, .verifyArmed,
    .verifyAddr);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clock);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
    end
  endtask
  task rdchk(input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  task w8(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    {reset_n, powerOnReset_n} <= 2'h3;
    rdchk(`FPEC_OFS_CTRL1, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({31'h0, err}, 32'h1);
    userMode <= 1'b1;
    apb(1'b1, `FPEC_OFS_RAMEMU, 32'h0000000D);
    cpu.acc(1'b0, 24'h000805, 8'h00);
    w8(0);
    chk({31'h0, overlayHit}, 32'h1);
    chk({8'h0, physAddr}, 32'h00FFE005);
    cpu.acc(1'b0, 24'hFFE005, 8'h00);
    w8(0);
    chk({8'h0, physAddr}, 32'h00FFE005);
    apb(1'b1, `FPEC_OFS_CTRL1, 32'h41);
    w8(3);
    chk({31'h0, writePulse}, 32'h0);
    apb(1'b1, `FPEC_OFS_CTRL1, 32'h0);
    apb(1'b1, `FPEC_OFS_RAMEMU, 32'h0);
    cpu.acc(1'b0, 24'h000805, 8'h00);
    w8(0);
    chk({31'h0, overlayHit}, 32'h0);
    userMode <= 1'b0;
    apb(1'b1, `FPEC_OFS_RAMEMU, 32'h0000000D);
    cpu.acc(1'b0, 24'h000805, 8'h00);
    w8(0);
    chk({31'h0, overlayHit}, 32'h0);
    apb(1'b1, `FPEC_OFS_RAMEMU, 32'h0);
    $display("test overlay done");
    apb(1'b1, `FPEC_OFS_CTRL1, 32'h1);
    w8(3);
    chk({31'h0, writePulse}, 32'h0);
    apb(1'b1, `FPEC_OFS_CTRL1, 32'h40);
    for (i = 0; i < 128; i = i + 1)
      cpu.acc(1'b1, {16'h0, 8'h80 | i[7:0]}, i < 8 ? i[7:0] : 8'hFF);
    w8(1);
    chk({31'h0, latchFull}, 32'h1);
    chk({8'h0, latchBase}, 32'h00000080);
    apb(1'b1, `FPEC_OFS_CTRL1, 32'h41);
    w8(3);
    chk({31'h0, writePulse}, 32'h1);
    chk({31'h0, irqMask}, 32'h1);
    standby <= 1'b1;
    w8(2);
    chk({31'h0, writePulse}, 32'h0);
    standby <= 1'b0;
    rdchk(`FPEC_OFS_CTRL1, 32'h0);
    $display("test program done");
    apb(1'b1, `FPEC_OFS_CTRL1, 32'h42);
    w8(3);
    chk({31'h0, clrPulse}, 32'h0);
    apb(1'b1, `FPEC_OFS_EBS1, 32'h1);
    apb(1'b1, `FPEC_OFS_CTRL1, 32'h40);
    apb(1'b1, `FPEC_OFS_CTRL1, 32'h42);
    w8(3);
    chk({31'h0, clrPulse}, 32'h1);
    chk({24'h0, eraseBlocks}, 32'h1);
    cpu.exc;
    w8(3);
    chk({31'h0, clrPulse}, 32'h0);
    rdchk(`FPEC_OFS_CTRL2, 32'h80);
    rdchk(`FPEC_OFS_EBS1, 32'h1);
    apb(1'b1, `FPEC_OFS_CTRL1, 32'h40);
    apb(1'b1, `FPEC_OFS_CTRL1, 32'h42);
    w8(3);
    chk({31'h0, clrPulse}, 32'h0);
    apb(1'b1, `FPEC_OFS_CTRL1, 32'h48);
    w8(3);
    chk({31'h0, clrCheck}, 32'h1);
    chk({31'h0, writeCheck}, 32'h0);
    apb(1'b1, `FPEC_OFS_CTRL1, 32'h44);
    w8(3);
    chk({31'h0, writeCheck}, 32'h1);
    cpu.acc(1'b1, 24'h000804, 8'hFF);
    w8(1);
    chk({31'h0, verifyArmed}, 32'h1);
    chk({8'h0, verifyAddr}, 32'h00000804);
    $display("test erase done");
    reset_n <= 1'b0;
    w8(1);
    reset_n <= 1'b1;
    rdchk(`FPEC_OFS_CTRL2, 32'h80);
    rdchk(`FPEC_OFS_EBS1, 32'h0);
    powerOnReset_n <= 1'b0;
    w8(1);
    powerOnReset_n <= 1'b1;
    rdchk(`FPEC_OFS_CTRL2, 32'h0);
    $display("test reset done");
    close_out;
  end
endmodule

// File: verif/fpec_flash_monitor.sv
`timescale 1ns/10ps
module fpec_flash_monitor (
  input wire clock,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire userMode,
  input wire standby,
  input wire exceptionTaken,
  input wire overlayHit,
  input wire [23:0] physAddr,
  input wire irqMask,
  input wire writePulse,
  input wire clrPulse,
  input wire [7:0] eraseBlocks
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_pready_next: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_overlay_user: assert property (overlayHit |-> $past(userMode))
    else $error("overlay outside user mode");
  a_overlay_ram: assert property (overlayHit |-> physAddr[23:10] == 14'h3FF8)
    else $error("overlay outside fixed ram");
  a_mode_single: assert property (!(writePulse && clrPulse))
    else $error("two modes at once");
  a_pulse_masked: assert property (writePulse || clrPulse |-> irqMask)
    else $error("interrupts open in mode");
  a_erase_block: assert property (clrPulse |-> eraseBlocks != 8'h00)
    else $error("erase with no block");
  a_fault_stop: assert property (exceptionTaken |-> ##[1:3] !writePulse && !clrPulse)
    else $error("mode kept after fault");
  a_standby_stop: assert property (standby |-> ##[1:2] !writePulse && !clrPulse)
    else $error("mode kept in standby");
endmodule
bind fpec_flash_ctrl fpec_flash_monitor u_mon (.clock, .reset_n, .psel,
  .penable, .pready, .userMode, .standby, .exceptionTaken, .overlayHit,
  .physAddr, .irqMask, .writePulse, .clrPulse, .eraseBlocks);
